// *** pin_ctl_pkg.sv ***
// Constants for the pin interrupt-enable and pin control registers
package pin_ctl_pkg;
  localparam int unsigned ADDR_W          = 8;
  localparam logic [7:0]  PIN_IRQ_EN_OFFS = 8'h0D;
  localparam logic [7:0]  PIN_CONTROL_OFFS = 8'h0E;
  localparam int unsigned CTL_LATCH_BIT   = 0;
  localparam int unsigned CTL_SEL_A_BIT   = 1;
  localparam int unsigned CTL_SEL_B_BIT   = 2;
  localparam int unsigned CTL_SRST_BIT    = 3;
  localparam logic [7:0]  IRQ_EN_RESET    = 8'h00;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  PIN_STATE_RESET = 8'hFF;
  localparam logic [7:0]  LOW_NIBBLE      = 8'h0F;
  localparam logic [7:0]  HIGH_NIBBLE     = 8'hF0;
  // Nibble positions of the modem lines, low nibble (channel B)
  localparam int unsigned MDM_RI_POS      = 3;
  localparam int unsigned MDM_CD_POS      = 2;
  localparam int unsigned MDM_TR_POS      = 1;
  localparam int unsigned MDM_SR_POS      = 0;
  localparam int unsigned HIGH_BASE       = 4;
  localparam logic [7:0]  TR_PIN_MASK     = 8'h22;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SRST_TIME_NS    = 40;
  localparam int unsigned SRST_CYCLES_I   =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  SRST_CYCLES     = 3'(SRST_CYCLES_I);
endpackage : pin_ctl_pkg

// *** pin_evt_if.sv ***
// Carrier between the register block and the pin event tracker
interface pin_evt_if;
  logic       latch_en;
  logic       state_read;
  logic       soft_rst;
  logic [7:0] pending;
  logic [7:0] held;
  logic [7:0] stable;
  modport tracker (input latch_en, input state_read, input soft_rst,
                   output pending, output held, output stable);
  modport ctrl    (output latch_en, output state_read, output soft_rst,
                   input pending, input held, input stable);
endinterface : pin_evt_if

// *** pin_evt_tracker.sv ***
// Pin synchroniser, change detection and optional latching per pin
module pin_evt_tracker
  import pin_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] pins_raw,
  pin_evt_if.tracker      evt
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] stable;
    logic [7:0] ref_val;
    logic [7:0] held;
    logic [7:0] pending;
  } trk_s;

  trk_s q;
  trk_s d;

  always_comb begin
    d    = q;
    d.s1 = pins_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 8; i++) begin
      // Change counts only once stages two and three agree
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
      // [R8] latch or follow
      if (evt.latch_en) begin
        if (!q.pending[i]) begin
          d.held[i]    = q.stable[i];
          d.pending[i] = q.stable[i] != q.ref_val[i];
        end
      end else begin
        d.held[i]    = q.stable[i];
        d.pending[i] = q.stable[i] != q.ref_val[i];
      end
    end
    // Read rebases; a still-differing pin re-flags next cycle, not lost
    if (evt.state_read) begin
      d.ref_val = q.held;
      d.pending = 8'h00;
    end
    if (evt.soft_rst) begin
      d.stable  = PIN_STATE_RESET;
      d.ref_val = PIN_STATE_RESET;
      d.held    = PIN_STATE_RESET;
      d.pending = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{s1: PIN_STATE_RESET, s2: PIN_STATE_RESET,
             s3: PIN_STATE_RESET, stable: PIN_STATE_RESET,
             ref_val: PIN_STATE_RESET, held: PIN_STATE_RESET,
             pending: 8'h00};
    end else begin
      q <= d;
    end
  end

  assign evt.pending = q.pending;
  assign evt.held    = q.held;
  assign evt.stable  = q.stable;
endmodule : pin_evt_tracker

// *** pin_irq_ctl.sv ***
// Pin interrupt enable, pin control, soft reset and modem pin muxing
// What this block does
// [R1] Eight interrupt-enable bits, one per pin; 1 enables, 0 disables.
// [R2] Enable bits of a nibble in modem use are ignored.
// [R3] Writing 1 to soft reset bit resets the registers and tracker, apart from read data and the synchroniser stages.
// [R4] Soft reset bit clears itself once the reset is over.
// [R5] Control bit 2 low: low nibble is plain pins.
// [R6] Control bit 2 high: low nibble carries channel B modem lines.
// [R7] Control bit 1 likewise gives high nibble to channel A modem lines.
// [R8] Latch bit holds a pin change until read, or lets it revert.
// [R9] Upper four control bits ignore writes and read as zero.
module pin_irq_ctl
  import pin_ctl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic              reg_wr_en,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd_en,
  output logic      [7:0]        reg_rdata,
  input  wire logic              pin_state_read,
  output logic      [7:0]        pin_state,
  input  wire logic [7:0]        pins_in,
  output logic      [7:0]        pins_out,
  output logic      [7:0]        pins_oe,
  output logic                   pin_irq,
  output logic                   soft_reset_n,
  output logic                   ring_indicate_a_n,
  output logic                   carrier_detect_a_n,
  output logic                   set_ready_a_n,
  input  wire logic              terminal_ready_a_n,
  output logic                   ring_indicate_b_n,
  output logic                   carrier_detect_b_n,
  output logic                   set_ready_b_n,
  input  wire logic              terminal_ready_b_n
);
  typedef struct packed {
    logic       latch_en;
    logic       sel_a;
    logic       sel_b;
    logic       srst_act;
    logic [2:0] srst_cnt;
    logic [7:0] irq_en;
    logic [7:0] rdata;
    logic       irq;
    logic [5:0] mdm;
  } ctl_s;

  ctl_s q;
  ctl_s d;

  pin_evt_if evt ();

  pin_evt_tracker u_tracker (
    .clk      (clk),
    .rst_n    (rst_n),
    .pins_raw (pins_in),
    .evt      (evt)
  );

  // Nibbles taken over by modem lines
  function automatic logic [7:0] modem_mask(input logic sa, input logic sb);
    modem_mask = (sa ? HIGH_NIBBLE : 8'h00) | (sb ? LOW_NIBBLE : 8'h00);
  endfunction : modem_mask

  // Modem inputs of one nibble as {ri, cd, sr}; idle high when unselected
  function automatic logic [2:0] modem_view(input logic       sel,
                                            input logic [3:0] nib);
    if (sel) begin
      modem_view = {nib[MDM_RI_POS], nib[MDM_CD_POS], nib[MDM_SR_POS]};
    end else begin
      modem_view = 3'h7;
    end
  endfunction : modem_view

  // Power-on state of the register block
  localparam ctl_s CTL_INIT = '{
    latch_en: CONTROL_RESET[CTL_LATCH_BIT],
    sel_a:    CONTROL_RESET[CTL_SEL_A_BIT],
    sel_b:    CONTROL_RESET[CTL_SEL_B_BIT],
    srst_act: 1'h0,
    srst_cnt: 3'h0,
    irq_en:   IRQ_EN_RESET,
    rdata:    8'h00,
    irq:      1'h0,
    mdm:      6'h3F
  };

  logic [7:0] ctl_read;
  logic       hit_ctl;
  logic       hit_en;
  logic       wr_open;
  logic       wr_ctl;
  logic       wr_en;
  logic       srst_done;
  logic [7:0] modem_nib;
  logic [7:0] irq_src;
  logic [2:0] mdm_a_in;
  logic [2:0] mdm_b_in;
  logic [1:0] tr_n;

  assign ctl_read = {4'h0, q.srst_act, q.sel_b, q.sel_a, q.latch_en};

  // Address decode shared by the read and write paths
  assign hit_ctl = reg_addr == PIN_CONTROL_OFFS;
  assign hit_en  = reg_addr == PIN_IRQ_EN_OFFS;

  // Writes during soft reset would be undone at its end anyway
  assign wr_open = reg_wr_en && !q.srst_act;
  assign wr_ctl  = wr_open && hit_ctl;
  assign wr_en   = wr_open && hit_en;

  // [R4] counter spent: the reset ends this cycle
  assign srst_done = q.srst_act && (q.srst_cnt == 3'h0);

  // [R2] modem nibbles mask enables
  assign modem_nib = modem_mask(q.sel_a, q.sel_b);
  // [R1] per-pin enable gate
  assign irq_src   = evt.pending & q.irq_en & ~modem_nib;

  // [R6] [R7] filtered levels, so modem lines never see raw glitches
  assign mdm_a_in = modem_view(q.sel_a, evt.stable[HIGH_BASE +: 4]);
  assign mdm_b_in = modem_view(q.sel_b, evt.stable[3:0]);

  always_comb begin
    d = q;

    // Registered read data; a read beside a write returns the old value
    if (reg_rd_en) begin
      if (hit_ctl) begin
        // [R9] reserved read zero
        d.rdata = ctl_read;
      end else if (hit_en) begin
        d.rdata = q.irq_en;
      end else begin
        d.rdata = 8'h00;
      end
    end

    if (srst_done) begin
      // [R4] self-clear after reset
      d.srst_act = 1'h0;
      d.latch_en = CONTROL_RESET[CTL_LATCH_BIT];
      d.sel_a    = CONTROL_RESET[CTL_SEL_A_BIT];
      d.sel_b    = CONTROL_RESET[CTL_SEL_B_BIT];
      d.irq_en   = IRQ_EN_RESET;
    end else if (q.srst_act) begin
      // Count down the reset span
      d.srst_cnt = q.srst_cnt - 3'h1;
    end else if (wr_ctl) begin
      // [R9] upper bits dropped
      d.latch_en = reg_wdata[CTL_LATCH_BIT];
      d.sel_a    = reg_wdata[CTL_SEL_A_BIT];
      d.sel_b    = reg_wdata[CTL_SEL_B_BIT];
      // [R3] start soft reset
      if (reg_wdata[CTL_SRST_BIT]) begin
        d.srst_act = 1'h1;
        d.srst_cnt = SRST_CYCLES - 3'h1;
      end
    end else if (wr_en) begin
      // [R1] per-pin enables
      d.irq_en = reg_wdata;
    end

    // Registered so pin_irq never glitches while enables change
    d.irq = |irq_src;
    d.mdm = {mdm_a_in, mdm_b_in};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= CTL_INIT;
    end else begin
      q <= d;
    end
  end

  assign evt.latch_en   = q.latch_en;
  assign evt.state_read = pin_state_read;
  // [R3] tracker included, apart from its s1-s3 synchroniser stages
  assign evt.soft_rst   = q.srst_act;

  assign reg_rdata    = q.rdata;
  assign pin_irq      = q.irq;
  assign soft_reset_n = ~q.srst_act;
  assign pin_state    = evt.held;

  // Terminal ready per channel; index 0 is channel B, low nibble
  assign tr_n = {terminal_ready_a_n, terminal_ready_b_n};

  // [R5] plain pins leave drive to the pin direction logic outside
  assign pins_oe = modem_nib & TR_PIN_MASK;

  // Only terminal ready is ever driven; the other bits idle high
  for (genvar ch = 0; ch < 2; ch++) begin : g_nib
    assign pins_out[ch*4 +: 4] = {2'h3, tr_n[ch], 1'h1};
  end

  assign ring_indicate_a_n  = q.mdm[5];
  assign carrier_detect_a_n = q.mdm[4];
  assign set_ready_a_n      = q.mdm[3];
  assign ring_indicate_b_n  = q.mdm[2];
  assign carrier_detect_b_n = q.mdm[1];
  assign set_ready_b_n      = q.mdm[0];
endmodule : pin_irq_ctl

// *** pin_irq_ctl_checker.sv ***
// Port assertions for the pin control block, with its bind
module pin_irq_ctl_checker
  import pin_ctl_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pins_oe,
  input wire logic       pin_irq,
  input wire logic       soft_reset_n,
  input wire logic       ring_indicate_a_n,
  input wire logic       ring_indicate_b_n,
  input wire logic       set_ready_b_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire ctl = reg_addr == PIN_CONTROL_OFFS;
  wire wr_ctl = reg_wr_en && ctl && soft_reset_n;
  wire rib_idle = ring_indicate_b_n && set_ready_b_n;
  property p_go; wr_ctl && reg_wdata[3] |=> !soft_reset_n; endproperty
  a_go: assert property (p_go) else $error("no soft reset");
  property p_len;
    $fell(soft_reset_n) |=> !soft_reset_n [*3] ##1 soft_reset_n;
  endproperty
  a_len: assert property (p_len) else $error("soft reset length");
  property p_clr;
    reg_rd_en && ctl && soft_reset_n && $past(soft_reset_n) |=> !reg_rdata[3];
  endproperty
  a_clr: assert property (p_clr) else $error("reset bit stuck");
  property p_sel;
    wr_ctl && !reg_wdata[3] |=>
      pins_oe[1] == $past(reg_wdata[2]) && pins_oe[5] == $past(reg_wdata[1]);
  endproperty
  a_sel: assert property (p_sel) else $error("select not taken");
  property p_oe; (pins_oe & ~TR_PIN_MASK) == 8'h00; endproperty
  a_oe: assert property (p_oe) else $error("stray drive");
  property p_b; !pins_oe[1] && !$past(pins_oe[1]) |-> rib_idle; endproperty
  a_b: assert property (p_b) else $error("modem b active");
  property p_a; !pins_oe[5] && !$past(pins_oe[5]) |-> ring_indicate_a_n;
  endproperty
  a_a: assert property (p_a) else $error("modem a active");
  property p_mdm;
    pins_oe == TR_PIN_MASK && $past(pins_oe) == TR_PIN_MASK |-> !pin_irq;
  endproperty
  a_mdm: assert property (p_mdm) else $error("modem irq");
  property p_rsv; reg_rd_en && ctl |=> reg_rdata[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  c_srst: cover property ($fell(soft_reset_n));
  c_irq: cover property ($rose(pin_irq));
  c_mdm: cover property (!ring_indicate_b_n);
endmodule : pin_irq_ctl_checker

bind pin_irq_ctl pin_irq_ctl_checker u_chk (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
  .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata), .pins_oe(pins_oe),
  .pin_irq(pin_irq), .soft_reset_n(soft_reset_n),
  .ring_indicate_a_n(ring_indicate_a_n),
  .ring_indicate_b_n(ring_indicate_b_n), .set_ready_b_n(set_ready_b_n));

// *** pin_irq_ctl_tb.sv ***
// Self-checking bench for the pin control block
module pin_irq_ctl_tb
  import pin_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst_n, wr, rd, psr, tra, trb;
  logic [7:0] addr, wd, rdat, pst, pout, poe, pin, lvl;
  logic       irq, srn, ria, cda, sra, rib, cdb, srb;
  int         err_count = 0;
  int         compares = 0;
  pin_irq_ctl uut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr),
    .reg_wdata(wd), .reg_rd_en(rd), .reg_rdata(rdat), .pin_state_read(psr),
    .pin_state(pst), .pins_in(pin), .pins_out(pout), .pins_oe(poe),
    .pin_irq(irq), .soft_reset_n(srn), .ring_indicate_a_n(ria),
    .carrier_detect_a_n(cda), .set_ready_a_n(sra), .terminal_ready_a_n(tra),
    .ring_indicate_b_n(rib), .carrier_detect_b_n(cdb), .set_ready_b_n(srb),
    .terminal_ready_b_n(trb));
  pin_partner u_pins (.pins_out(pout), .pins_oe(poe), .ext_level(lvl),
    .pins_in(pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Idle edge after each strobe keeps drives one per time step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    {addr, wd, wr} = {a, d, 1'b1};
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    {addr, rd} = {a, 1'b1};
    tick(1);
    rd = 1'b0;
    chk("rdata", rdat, e);
    tick(1);
  endtask : rd_reg
  task automatic final_report;
    $display("compares %0d, err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    #20000;
    err_count++;
    final_report();
  end
  initial begin
    {wr, rd, psr, tra, trb, rst_n} = 6'b000110;
    {addr, wd, lvl} = 24'h0000FF;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(1);
    rd_reg(PIN_IRQ_EN_OFFS, IRQ_EN_RESET);
    rd_reg(PIN_CONTROL_OFFS, CONTROL_RESET);
    rd_reg(8'h33, 8'h00);
    wr_reg(PIN_CONTROL_OFFS, 8'hF0);
    rd_reg(PIN_CONTROL_OFFS, 8'h00);
    wr_reg(PIN_IRQ_EN_OFFS, 8'h01);
    lvl = 8'hFE;
    tick(8);
    chk("irq", {7'h00, irq}, 8'h01);
    wr_reg(PIN_IRQ_EN_OFFS, 8'h00);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(PIN_IRQ_EN_OFFS, 8'h01);
    lvl = 8'hFF;
    tick(8);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(PIN_CONTROL_OFFS, 8'h01);
    lvl = 8'hFE;
    tick(8);
    lvl = 8'hFF;
    tick(8);
    chk("irq", {7'h00, irq}, 8'h01);
    chk("state", pst, 8'hFE);
    psr = 1'b1;
    tick(1);
    psr = 1'b0;
    tick(3);
    // Pin left the value just read: a fresh change
    chk("irq", {7'h00, irq}, 8'h01);
    chk("state", pst, 8'hFF);
    psr = 1'b1;
    tick(1);
    psr = 1'b0;
    tick(3);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(PIN_IRQ_EN_OFFS, 8'hFF);
    wr_reg(PIN_CONTROL_OFFS, 8'h04);
    {lvl, trb} = {8'hF7, 1'b0};
    tick(8);
    chk("oe", poe, 8'h02);
    chk("mdm_b", {5'h00, rib, cdb, srb}, 8'h03);
    chk("out", pout & TR_PIN_MASK, 8'h20);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(PIN_CONTROL_OFFS, 8'h06);
    lvl = 8'h77;
    tick(8);
    chk("oe", poe, 8'h22);
    chk("mdm_a", {5'h00, ria, cda, sra}, 8'h03);
    chk("irq", {7'h00, irq}, 8'h00);
    wr_reg(PIN_CONTROL_OFFS, 8'h00);
    chk("mdm", {6'h00, ria, rib}, 8'h03);
    wr_reg(PIN_IRQ_EN_OFFS, 8'h5A);
    wr_reg(PIN_CONTROL_OFFS, 8'h08);
    chk("srst", {7'h00, srn}, 8'h00);
    rd_reg(PIN_CONTROL_OFFS, 8'h08);
    tick(4);
    rd_reg(PIN_CONTROL_OFFS, 8'h00);
    rd_reg(PIN_IRQ_EN_OFFS, 8'h00);
    final_report();
  end
endmodule : pin_irq_ctl_tb

// *** pin_partner.sv ***
// Pin-side model: pins follow ext_level, driven back where the block drives
module pin_partner (
  input  wire logic [7:0] pins_out,
  input  wire logic [7:0] pins_oe,
  input  wire logic [7:0] ext_level,
  output logic      [7:0] pins_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext_level);
endmodule : pin_partner
